// ---- risc_fetch_model.sv ----
/* model of the risc controller fetching microcode words.
   assumes the same clock as the lock block; the bench reads the answer. */
`timescale 1ns/100ps
`default_nettype none
module risc_fetch_model (
	input wire logic aclk,
	output logic risc_fetch_req,
	output logic [10:0] risc_fetch_addr
);
	// idle with no request and a meaningless address
	initial begin
		risc_fetch_req = 1'b0;
		risc_fetch_addr = 11'h7ff;
	end
	// one word per request, after a gap; address scrambled once released
	task fetch(input logic [10:0] a, input int gap);
		repeat (gap) @(posedge aclk);
		risc_fetch_req <= 1'b1;
		risc_fetch_addr <= a;
		@(posedge aclk);
		risc_fetch_req <= 1'b0;
		risc_fetch_addr <= ~a;
		@(posedge aclk);
	endtask
endmodule // risc_fetch_model
`default_nettype wire

// ---- tb.sv ----
/* testbench: region settings, ram reads and fetches over twelve sample addresses.
   assumes the lock block, its defines header and the fetch model. */
`timescale 1ns/100ps
`default_nettype none
`include "ucode_lock_defines.vh"
module tb;
	logic aclk = 0, aresetn = 0, ce = 1;
	logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, risc_fetch_data, d, x;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, risc_fetch_req, f;
	logic risc_fetch_ack, risc_fetch_fault;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [10:0] risc_fetch_addr;
	int error_cnt = 0, n_checks = 0, cyc = 0;
	logic [15:0] al[12] = '{16'h0000, 16'h01fc, 16'h0200, 16'h0400, 16'h07fc,
		16'h0800, 16'h0900, 16'h0a00, 16'h1000, 16'h19fc, 16'h1a00, 16'h1c00};
	logic [2:0] cf[6] = '{3'b000, 3'b010, 3'b100, 3'b110, 3'b001, 3'b111};
	ucode_lock ucode_lock_inst (.*);
	risc_fetch_model risc_fetch_model_inst (.*);
	initial begin
		forever #2 aclk = ~aclk;
	end
	task end_sim;
		if (error_cnt == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one axi write; bready stands from the request until bvalid is seen
	task wr(input logic [15:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, 32'h0);
		@(posedge aclk);
	endtask
	// one axi read; data taken at the edge that sees rvalid with rready
	task rd(input logic [15:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge aclk);
	endtask
	// locked system ram for a size code and the upper-half enable
	function automatic logic lk(input logic [15:0] a, input logic [1:0] s,
		input logic e);
		logic [15:0] top;
		top = (s == 2'h3) ? 16'h0a00 : 16'h0900;
		return (s != 2'h0 && (a < (16'h0100 << s) || (a >= 16'h0800 && a < top)))
			|| (e && a >= 16'h1000 && a < 16'h1a00);
	endfunction
	// cut a hang short
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim;
		end
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`ADDR_REGION_CTRL);
		chk(d, 32'h0);
		foreach (al[i]) wr(al[i], {16'hc3c3, al[i]});
		foreach (cf[k]) begin
			wr(`ADDR_RISC_CONFIG, {30'h0, cf[k][2:1]});
			wr(`ADDR_REGION_CTRL, {31'h0, cf[k][0]});
			rd(`ADDR_REGION_CTRL);
			chk(d, {31'h0, cf[k][0]});
			rd(`ADDR_RISC_CONFIG);
			chk(d, {30'h0, cf[k][2:1]});
			foreach (al[i]) begin
				rd(al[i]);
				x = lk(al[i], cf[k][2:1], cf[k][0]) ? 32'hffffffff : {16'hc3c3, al[i]};
				chk(d, x);
				risc_fetch_model_inst.fetch(al[i][12:2], i % 2);
				chk({31'h0, risc_fetch_ack}, 32'h1);
				f = !(al[i] < 16'h0800 ||
					(cf[k][0] && al[i] >= 16'h1000 && al[i] < 16'h1a00));
				chk({31'h0, risc_fetch_fault}, {31'h0, f});
				chk(risc_fetch_data, f ? 32'h0 : {16'hc3c3, al[i]});
			end
		end
		wr(16'h1000, 32'h0);
		wr(`ADDR_REGION_CTRL, 32'h0);
		rd(16'h1000);
		chk(d, 32'hc3c31000);
		rd(`ADDR_BLOCKED_CNT);
		chk(d, 32'h1);
		rd(16'h3000);
		chk({30'h0, r}, 32'h3);
		chk(d, 32'h0);
		// read and write answers pending while ce is low must stand still
		s_axi_araddr <= `ADDR_BLOCKED_CNT;
		s_axi_awaddr <= `ADDR_RISC_CONFIG;
		s_axi_wdata <= 32'h0000a5a5;
		s_axi_arvalid <= 1'b1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		@(posedge aclk);
		ce <= 1'b0;
		repeat (3) @(posedge aclk);
		chk({30'h0, s_axi_rvalid, s_axi_bvalid}, 32'h3);
		ce <= 1'b1;
		s_axi_rready <= 1'b1;
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
		s_axi_bready <= 1'b0;
		chk(s_axi_rdata, 32'h1);
		chk({30'h0, s_axi_bresp}, 32'h0);
		@(posedge aclk);
		rd(`ADDR_RISC_CONFIG);
		chk(d, 32'h0000a5a5);
		end_sim;
	end
endmodule // tb
`default_nettype wire

// ---- ucode_lock.v ----
/*
 * dual-port ram with microcode region locking, axi4-lite register and
 * ram access for software, and a fetch port for the risc controller.
 * assumes one clock, synchronous active-low reset, fetch port driven by
 * logic on the same clock.
 */
// Design decision made here: the AXI4-Lite interface to the registers.
// Summary of operation
// - 8-bit region control register, reset zero
// - enable clear: execute only lowest 2 kbytes
// - enable set: also upper 2k plus extension
// - enable locks upper 2k block plus 512
// - reads of locked system ram return ones
// - size field selects one, two, four blocks
// - one or two blocks lock 256-byte extension
// - four blocks lock 512-byte extension
// - next 2-kbyte system area locked only in its first 256 or 512 bytes (extension)
// - parameter ram never locked
// - 8 kbytes: 7k system, 1k parameter
// - executable space from enable alone, not size
`timescale 1ns/100ps
`default_nettype none
`include "ucode_lock_defines.vh"

module ucode_lock (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire [15:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [15:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire risc_fetch_req,
	input wire [10:0] risc_fetch_addr,
	output reg risc_fetch_ack,
	output reg [31:0] risc_fetch_data,
	output reg risc_fetch_fault
);

// 2048 words: system ram below the parameter ram at the top kbyte
reg [31:0] mem [0:2047];

reg [15:0] risc_config_reg;
reg upper_half_ucode_enable;
reg [15:0] blocked_write_count;

reg aw_held;
reg w_held;
reg [15:0] aw_addr_q;
reg [31:0] w_data_q;
reg [3:0] w_strb_q;

wire [1:0] ucode_size_select;
wire wr_locked;
wire rd_locked;
wire fetch_exec_ok;
wire wr_is_ram;
wire rd_is_ram;
wire wr_go;
wire [31:0] rd_value;
wire [1:0] rd_resp;
wire [7:0] region_ctrl_value;
integer lane;

assign ucode_size_select =
	risc_config_reg[`SIZE_SEL_MSB:`SIZE_SEL_LSB];

// ram occupies the first 8 kbytes of the bus window
assign wr_is_ram = (aw_addr_q[15:13] == 3'h0);
assign rd_is_ram = (s_axi_araddr[15:13] == 3'h0);

// reserved bits of the region control register read back as zero
assign region_ctrl_value = {7'h00, upper_half_ucode_enable};

// region decode for the pending software write
ucode_region_map u_map_wr (
	.word_addr(aw_addr_q[12:2]),
	.ucode_size_select(ucode_size_select),
	.upper_half_ucode_enable(upper_half_ucode_enable),
	.locked(wr_locked),
	.exec_ok()
);

// region decode for the software read being taken
ucode_region_map u_map_rd (
	.word_addr(s_axi_araddr[12:2]),
	.ucode_size_select(ucode_size_select),
	.upper_half_ucode_enable(upper_half_ucode_enable),
	.locked(rd_locked),
	.exec_ok()
);

// region decode for the controller's fetch
ucode_region_map u_map_fetch (
	.word_addr(risc_fetch_addr),
	.ucode_size_select(ucode_size_select),
	.upper_half_ucode_enable(upper_half_ucode_enable),
	.locked(),
	.exec_ok(fetch_exec_ok)
);

// write happens once both address and data are held and no answer waits
assign wr_go = aw_held & w_held & ~s_axi_bvalid;

// read data mux: ram, registers, or decode error
assign rd_value = rd_is_ram ? (rd_locked ? 32'hffffffff :
	mem[s_axi_araddr[12:2]]) :
	(s_axi_araddr == `ADDR_RISC_CONFIG) ? {16'h0000, risc_config_reg} :
	(s_axi_araddr == `ADDR_REGION_CTRL) ? {24'h000000, region_ctrl_value} :
	(s_axi_araddr == `ADDR_BLOCKED_CNT) ? {16'h0000, blocked_write_count} :
	32'h00000000;

assign rd_resp = (rd_is_ram || s_axi_araddr == `ADDR_RISC_CONFIG ||
	s_axi_araddr == `ADDR_REGION_CTRL ||
	s_axi_araddr == `ADDR_BLOCKED_CNT) ? `RESP_OKAY : `RESP_DECERR;

// write address and write data channels, taken in either order
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr_q <= 16'h0000;
		w_data_q <= 32'h00000000;
		w_strb_q <= 4'h0;
	end else if (ce) begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_addr_q <= s_axi_awaddr;
			aw_held <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
			w_held <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		if (wr_go) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

// write response, one cycle after both halves are held
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `RESP_OKAY;
	end else if (ce) begin
		if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			if (wr_is_ram || aw_addr_q == `ADDR_RISC_CONFIG ||
				aw_addr_q == `ADDR_REGION_CTRL ||
				aw_addr_q == `ADDR_BLOCKED_CNT) begin
				s_axi_bresp <= `RESP_OKAY;
			end else begin
				s_axi_bresp <= `RESP_DECERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// control registers and the count of refused ram writes
always @(posedge aclk) begin
	if (!aresetn) begin
		risc_config_reg <= `RST_RISC_CONFIG;
		upper_half_ucode_enable <= `RST_REGION_CTRL;
		blocked_write_count <= 16'h0000;
	end else if (ce && wr_go) begin
		if (aw_addr_q == `ADDR_RISC_CONFIG) begin
			if (w_strb_q[0]) begin
				risc_config_reg[7:0] <= w_data_q[7:0];
			end
			if (w_strb_q[1]) begin
				risc_config_reg[15:8] <= w_data_q[15:8];
			end
		end
		// only the enable bit is stored; bits 1-7 are expected zero
		if (aw_addr_q == `ADDR_REGION_CTRL && w_strb_q[0]) begin
			upper_half_ucode_enable <= w_data_q[`BIT_UPPER_EN];
		end
		if (wr_is_ram && wr_locked && w_strb_q != 4'h0 &&
			blocked_write_count != 16'hffff) begin
			blocked_write_count <= blocked_write_count + 16'h0001;
		end
	end
end

// ram byte writes from software, dropped inside locked areas
always @(posedge aclk) begin
	if (ce && wr_go && wr_is_ram && !wr_locked) begin
		for (lane = 0; lane < 4; lane = lane + 1) begin
			if (w_strb_q[lane]) begin
				mem[aw_addr_q[12:2]][lane*8 +: 8] <= w_data_q[lane*8 +: 8];
			end
		end
	end
end

// read channel: data registered at the same edge that takes the address
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `RESP_OKAY;
	end else if (ce) begin
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_value;
			s_axi_rresp <= rd_resp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

// controller fetch port: one-cycle answer, fault outside executable space
always @(posedge aclk) begin
	if (!aresetn) begin
		risc_fetch_ack <= 1'b0;
		risc_fetch_data <= 32'h00000000;
		risc_fetch_fault <= 1'b0;
	end else if (ce) begin
		risc_fetch_ack <= risc_fetch_req;
		if (risc_fetch_req) begin
			risc_fetch_data <= fetch_exec_ok ? mem[risc_fetch_addr] :
				32'h00000000;
			risc_fetch_fault <= ~fetch_exec_ok;
		end
	end
end

endmodule // ucode_lock

`default_nettype wire

// ---- ucode_lock_defines.vh ----
/*
 * constants for the dual-port ram microcode lock: register indices and
 * byte addresses, field positions, reset values and the region boundaries.
 * assumes it is included by bare name from design files and the testbench.
 */
`ifndef UCODE_LOCK_DEFINES_VH
`define UCODE_LOCK_DEFINES_VH

// register indices in the communications processor area
`define IDX_RISC_CONFIG 16'h09c4
`define IDX_REGION_CTRL 16'h09c7
`define IDX_BLOCKED_CNT 16'h09c8
// byte addresses on the bus are four times the index
`define ADDR_RISC_CONFIG 16'h2710
`define ADDR_REGION_CTRL 16'h271c
`define ADDR_BLOCKED_CNT 16'h2720

// field positions
`define BIT_UPPER_EN 0
`define SIZE_SEL_LSB 0
`define SIZE_SEL_MSB 1

// reset values
`define RST_RISC_CONFIG 16'h0000
`define RST_REGION_CTRL 1'b0

// microcode size codes
`define SIZE_NONE 2'h0
`define SIZE_ONE 2'h1
`define SIZE_TWO 2'h2
`define SIZE_FOUR 2'h3

// region boundaries as 32-bit word indices into the 8-kbyte ram
`define W_BLK1_END 11'h080
`define W_BLK2_END 11'h100
`define W_LOW_2K_END 11'h200
`define W_EXT256_END 11'h240
`define W_EXT512_END 11'h280
`define W_UPPER_BASE 11'h400
`define W_UPPER_END 11'h600
`define W_UPPER_EXT_END 11'h680
`define W_PARAM_BASE 11'h700

// bus answers
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ---- ucode_lock_sva.sv ----
/* checker for the microcode lock block: fetch answers and axi answers.
   assumes one clock, synchronous active-low reset, bound to the top. */
`timescale 1ns/100ps
`default_nettype none
module ucode_lock_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic risc_fetch_req,
	input wire logic [10:0] risc_fetch_addr,
	input wire logic risc_fetch_ack,
	input wire logic risc_fetch_fault
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_fetch_ack_pulse: assert property (
		ce && risc_fetch_req |=> risc_fetch_ack)
		else $error("fetch not acknowledged");
	a_fetch_ack_idle: assert property (
		ce && !risc_fetch_req |=> !risc_fetch_ack)
		else $error("fetch ack without request");
	a_low_exec_ok: assert property (
		ce && risc_fetch_req && risc_fetch_addr < 11'h200
		|=> !risc_fetch_fault) else $error("low 2k fetch faulted");
	a_gap_exec_bad: assert property (
		ce && risc_fetch_req && risc_fetch_addr >= 11'h200
		&& risc_fetch_addr < 11'h400 |=> risc_fetch_fault)
		else $error("fetch from data area allowed");
	a_top_exec_bad: assert property (
		ce && risc_fetch_req && risc_fetch_addr >= 11'h680
		|=> risc_fetch_fault) else $error("fetch past extension allowed");
	a_read_answer: assert property (
		ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_rvalid_hold: assert property (
		s_axi_rvalid && !(ce && s_axi_rready) |=> s_axi_rvalid)
		else $error("read answer dropped");
	a_bvalid_hold: assert property (
		s_axi_bvalid && !(ce && s_axi_bready) |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_ram_read_okay: assert property (
		ce && s_axi_arvalid && s_axi_arready && s_axi_araddr < 16'h2000
		|=> s_axi_rresp == 2'h0) else $error("ram read not okay");
	a_unmapped_err: assert property (
		ce && s_axi_arvalid && s_axi_arready && s_axi_araddr >= 16'h3000
		|=> s_axi_rresp == 2'h3) else $error("unmapped read not refused");
	a_frozen_hold: assert property (
		!ce |=> $stable(risc_fetch_ack) && $stable(s_axi_rvalid)
		&& $stable(s_axi_bvalid)) else $error("state moved while frozen");
endmodule // ucode_lock_sva
bind ucode_lock ucode_lock_sva ucode_lock_sva_inst (.*);
`default_nettype wire

// ---- ucode_region_map.v ----
/*
 * combinational region decoder: tells whether a ram word is locked for
 * microcode and whether the risc controller may execute from it.
 * assumes word indices of the 8-kbyte ram and stable control inputs.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ucode_lock_defines.vh"

module ucode_region_map (
	input wire [10:0] word_addr,
	input wire [1:0] ucode_size_select,
	input wire upper_half_ucode_enable,
	output wire locked,
	output wire exec_ok
);

wire in_blocks;
wire in_low_ext;
wire in_upper;
wire in_param;

// selected 512-byte blocks at the bottom of system ram
assign in_blocks = (ucode_size_select == `SIZE_ONE &&
	word_addr < `W_BLK1_END) ||
	(ucode_size_select == `SIZE_TWO && word_addr < `W_BLK2_END) ||
	(ucode_size_select == `SIZE_FOUR && word_addr < `W_LOW_2K_END);

// extension above the lower blocks: 256 bytes for one or two, 512 for four
assign in_low_ext = ((ucode_size_select == `SIZE_ONE ||
	ucode_size_select == `SIZE_TWO) && word_addr >= `W_LOW_2K_END &&
	word_addr < `W_EXT256_END) ||
	(ucode_size_select == `SIZE_FOUR && word_addr >= `W_LOW_2K_END &&
	word_addr < `W_EXT512_END);

// upper 2-kbyte block plus its 512-byte extension
assign in_upper = upper_half_ucode_enable && word_addr >= `W_UPPER_BASE &&
	word_addr < `W_UPPER_EXT_END;

assign in_param = word_addr >= `W_PARAM_BASE;

// parameter ram and the free system areas fall outside every range
assign locked = ~in_param &
	(in_blocks | in_low_ext | in_upper);

// execution: lowest 2 kbytes always, upper area only when enabled
assign exec_ok = (word_addr < `W_LOW_2K_END) |
	in_upper;

endmodule // ucode_region_map

`default_nettype wire
